// >>> bench/dht_pin_src.sv
// Purpose: far-side square-wave source for the clock-mode pin
// Assumes: each level lasts HALF mclk cycles, well above sync needs
// Notes: stands low while not running, like a gated crystal
`timescale 1ns/1ps
module dht_pin_src #(
  parameter int HALF = 4
) (
  input wire logic mclk,
  input wire logic run,
  output logic pin,
  output int rises
);
  int ph;
  initial begin
    pin = 1'b0;
    rises = 0;
    ph = 0;
  end
  // slow clock stands in for the 32.768 khz source
  always @(posedge mclk) begin
    if (!run) begin
      pin <= 1'b0;
      ph <= 0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      pin <= ~pin;
      if (!pin) rises <= rises + 1;
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

// >>> bench/testbench.sv
// Purpose: self-checking bench for dht_timer
// Assumes: RTC_DIV of 4, so one clock tick per four pin rises
// Notes: conv_trig pulses are stamped to measure periods
`timescale 1ns/1ps
`include "dht_timer_regs.svh"
module testbench
  import dht_pkg::*;
();
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } dht_row_t;
  dht_row_t rows [17] = '{
    '{1'b0, `DHT_OFS_CFG, 32'h0, 32'h0}, '{1'b0, `DHT_OFS_AMODE, 32'h0, 32'h0},
    '{1'b0, `DHT_OFS_CTL, 32'h0, 32'h0}, '{1'b0, `DHT_OFS_IMR, 32'h0, 32'h0},
    '{1'b0, `DHT_OFS_RIS, 32'h0, 32'h0}, '{1'b0, `DHT_OFS_MIS, 32'h0, 32'h0},
    '{1'b0, `DHT_OFS_AILR, 32'h0, 32'hffffffff}, '{1'b0, `DHT_OFS_BILR, 32'h0, 32'hffff},
    '{1'b0, `DHT_OFS_APR, 32'h0, 32'h0}, '{1'b0, `DHT_OFS_BPR, 32'h0, 32'h0},
    '{1'b0, `DHT_OFS_AR, 32'h0, 32'hffffffff}, '{1'b0, `DHT_OFS_BR, 32'h0, 32'hffff},
    '{1'b1, 8'h40, 32'h5, 32'h0}, '{1'b1, `DHT_OFS_APR, 32'h1ff, 32'hff},
    '{1'b1, `DHT_OFS_BMODE, 32'h1, 32'h1}, '{1'b1, `DHT_OFS_ICR, 32'h9, 32'h0},
    '{1'b1, `DHT_OFS_IMR, 32'hffffffff, 32'h109}};
  logic mclk, srst, dbg_halt, other_trig, irq, conv_trig, run, pin;
  dht_wb_req_t wb_req;
  dht_wb_rsp_t wb_rsp;
  int rises, num_errors, checks_done, cyc_n, trig_n, t_prev, t_last, tn;
  dht_timer #(.RTC_DIV(4)) dut (.mclk(mclk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .dbg_halt(dbg_halt), .capture_compare_pin(pin), .other_trig(other_trig), .irq(irq),
    .conv_trig(conv_trig));
  dht_pin_src #(.HALF(4)) src (.mclk(mclk), .run(run), .pin(pin), .rises(rises));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one block stamps pulses and guards against hangs, so no race on cyc_n
  always @(posedge mclk) begin
    cyc_n++;
    if (conv_trig === 1'b1) begin
      trig_n++;
      t_prev = t_last;
      t_last = cyc_n;
    end
    if (cyc_n == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input logic [31:0] lo, hi, g);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      num_errors++;
      $display("wrong value %s expected %h to %h seen %h", nm, lo, hi, g);
    end
  endtask
  // request held until ack is sampled, released on that same edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] sel, output logic [31:0] r);
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: a, dat: d};
    @(posedge mclk);
    while (wb_rsp.ack !== 1'b1) @(posedge mclk);
    r = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hf, r);
    chk(nm, e, r);
  endtask
  task automatic wait_ris(input logic [31:0] m);
    logic [31:0] r;
    r = 32'h0;
    while ((r & m) == 32'h0) wb(1'b0, `DHT_OFS_RIS, 32'h0, 4'hf, r);
  endtask
  task automatic wait_trig(input int k);
    int n;
    n = trig_n + k;
    while (trig_n < n) @(posedge mclk);
  endtask
  task automatic pulses(input int k);
    int n;
    n = rises + k;
    run <= 1'b1;
    while (rises < n) @(posedge mclk);
    run <= 1'b0;
  endtask
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    srst = 1'b1;
    wb_req = '0;
    dbg_halt = 1'b0;
    other_trig = 1'b0;
    run = 1'b0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      if (rows[i].we) wr(rows[i].adr, rows[i].dat);
      wb(1'b0, rows[i].adr, 32'h0, 4'hf, a);
      chk($sformatf("reg %h", rows[i].adr), rows[i].exp, a);
    end
    wb(1'b1, `DHT_OFS_BILR, 32'h7, 4'h3, a);
    rdc("lane write", `DHT_OFS_BILR, 32'hffff);
    $display("test registers done");
    wr(`DHT_OFS_AMODE, 32'h1);
    wr(`DHT_OFS_AILR, 32'h0001_0000);
    rdc("second load", `DHT_OFS_BILR, 32'h1);
    rdc("joint count", `DHT_OFS_AR, 32'h0001_0000);
    rdc("second count", `DHT_OFS_BR, 32'h1);
    wr(`DHT_OFS_AILR, 32'h5);
    tn = trig_n;
    wr(`DHT_OFS_CTL, 32'h1);
    wait_ris(32'h1);
    rdc("one-shot enable", `DHT_OFS_CTL, 32'h0);
    rdc("reloaded", `DHT_OFS_AR, 32'h5);
    rdc("masked", `DHT_OFS_MIS, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    chk("no trigger", tn, trig_n);
    repeat (20) @(posedge mclk);
    rdc("raw held", `DHT_OFS_RIS, 32'h1);
    wr(`DHT_OFS_ICR, 32'h1);
    rdc("raw cleared", `DHT_OFS_RIS, 32'h0);
    chk("irq low", 32'h0, {31'h0, irq});
    wr(`DHT_OFS_CTL, 32'h100);
    repeat (10) @(posedge mclk);
    rdc("joint held", `DHT_OFS_AR, 32'h5);
    rdc("no lone half", `DHT_OFS_RIS, 32'h0);
    $display("test joint one-shot done");
    wr(`DHT_OFS_AMODE, 32'h2);
    wr(`DHT_OFS_CTL, 32'h21);
    wait_trig(3);
    chk("joint period", 32'd6, t_last - t_prev);
    rdc("periodic enable", `DHT_OFS_CTL, 32'h21);
    wr(`DHT_OFS_AILR, 32'd1000);
    wb(1'b0, `DHT_OFS_AR, 32'h0, 4'hf, a);
    chk_in("new load", 32'd990, 32'd1000, a);
    wr(`DHT_OFS_CTL, 32'h23);
    dbg_halt <= 1'b1;
    wb(1'b0, `DHT_OFS_AR, 32'h0, 4'hf, a);
    repeat (10) @(posedge mclk);
    wb(1'b0, `DHT_OFS_AR, 32'h0, 4'hf, b);
    chk("stalled", a, b);
    dbg_halt <= 1'b0;
    wb(1'b0, `DHT_OFS_AR, 32'h0, 4'hf, b);
    chk_in("resumed", 32'h0, a - 32'h1, b);
    wr(`DHT_OFS_CTL, 32'h0);
    wr(`DHT_OFS_ICR, 32'h109);
    tn = trig_n;
    other_trig <= 1'b1;
    @(posedge mclk);
    other_trig <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("merged trigger", tn + 1, trig_n);
    $display("test joint periodic done");
    wr(`DHT_OFS_CFG, 32'h4);
    wr(`DHT_OFS_APR, 32'h3);
    wr(`DHT_OFS_AILR, 32'h4);
    wr(`DHT_OFS_BILR, 32'h2);
    wr(`DHT_OFS_CTL, 32'h121);
    wait_trig(3);
    chk("prescaled period", 32'd20, t_last - t_prev);
    rdc("halves apart", `DHT_OFS_CTL, 32'h21);
    rdc("both timed out", `DHT_OFS_RIS, 32'h101);
    rdc("second reload", `DHT_OFS_BR, 32'h2);
    wb(1'b0, `DHT_OFS_AR, 32'h0, 4'hf, a);
    chk_in("half count", 32'h0, 32'h4, a);
    wr(`DHT_OFS_CTL, 32'h0);
    wr(`DHT_OFS_ICR, 32'h109);
    $display("test split done");
    wr(`DHT_OFS_CFG, 32'h1);
    rdc("first count", `DHT_OFS_AR, 32'h1);
    wr(`DHT_OFS_AMATCH, 32'h100);
    wr(`DHT_OFS_CTL, 32'h13);
    dbg_halt <= 1'b1;
    pulses(8);
    repeat (8) @(posedge mclk);
    rdc("ticks", `DHT_OFS_AR, 32'h3);
    wr(`DHT_OFS_AMATCH, 32'h3);
    pulses(4);
    repeat (8) @(posedge mclk);
    rdc("rolled over", `DHT_OFS_AR, 32'h0);
    rdc("match raw", `DHT_OFS_RIS, 32'h8);
    rdc("match masked", `DHT_OFS_MIS, 32'h8);
    chk("match irq", 32'h1, {31'h0, irq});
    pulses(4);
    repeat (8) @(posedge mclk);
    rdc("counts on", `DHT_OFS_AR, 32'h1);
    wr(`DHT_OFS_ICR, 32'h8);
    rdc("match cleared", `DHT_OFS_MIS, 32'h0);
    dbg_halt <= 1'b0;
    $display("test clock mode done");
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rdc("reset count", `DHT_OFS_AR, 32'hffffffff);
    rdc("reset control", `DHT_OFS_CTL, 32'h0);
    rdc("reset config", `DHT_OFS_CFG, 32'h0);
    rdc("reset mask", `DHT_OFS_IMR, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule

// >>> rtl/dht_pkg.sv
// Purpose: bus carrier types for the dual half timer
// Assumes: classic wishbone, 8-bit byte address
// Notes: numbers live in dht_timer_regs.svh
package dht_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } dht_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dht_wb_rsp_t;
endpackage

// >>> rtl/dht_timer.sv
// Purpose: two 16-bit timers, joinable into a 32-bit down timer or 1 Hz clock
// Assumes: mclk 125 MHz, srst synchronous active high, clock-mode pin asynchronous, resynchronised inside
// Notes: registers behind a classic wishbone slave; partial-lane writes are ignored
`timescale 1ns/1ps
`include "dht_timer_regs.svh"
module dht_timer
  import dht_pkg::*;
#(
  parameter int RTC_DIV = `DHT_CLOCK_IN_HZ / `DHT_CLOCK_OUT_HZ
) (
  input wire logic mclk,
  input wire logic srst,
  input wire dht_wb_req_t wb_req,
  output dht_wb_rsp_t wb_rsp,
  input wire logic dbg_halt,
  input wire logic capture_compare_pin,
  input wire logic other_trig,
  output logic irq,
  output logic conv_trig
);
  localparam logic [15:0] DIV_LAST = 16'(RTC_DIV - 1);

  logic ack_r;
  logic [31:0] rdat_r;
  logic [2:0] width_config_select;
  logic [1:0] mode_r [2];
  logic [15:0] timer_control_reg;
  logic [15:0] event_mask_reg;
  logic [15:0] raw_event_status_reg;
  logic [15:0] cnt_r [2];
  logic [15:0] ld_r [2];
  logic [7:0] pr_r [2];
  logic [7:0] psc_r [2];
  logic [31:0] first_half_match_value;
  logic [2:0] pin_s_r;
  logic [15:0] div_r;
  logic irq_r;
  logic trig_r;

  logic req;
  logic wr;
  logic [31:0] wdat;
  logic mode32;
  logic is_clk;
  logic [1:0] en;
  logic [1:0] stall;
  logic [1:0] ote;
  logic [1:0] run;
  logic [1:0] oneshot;
  logic [1:0] ld_wr;
  logic [1:0] step;
  logic [1:0] to16;
  logic to32;
  logic clk_sel_wr;
  logic [31:0] cnt32;
  logic [31:0] ld32;
  logic pin_rise;
  logic tick;
  logic match_ev;
  logic [15:0] ev;
  logic [15:0] clr;
  logic [31:0] rd_mux;

  assign req = wb_req.cyc & wb_req.stb;
  // write commits at the edge where ack is seen, as the master expects
  assign wr = req & wb_req.we & ack_r & (wb_req.sel == 4'hf);
  assign wdat = wb_req.dat;
  assign mode32 = (width_config_select == `DHT_CFG_JOINT) ||
                  (width_config_select == `DHT_CFG_CLOCK);
  assign is_clk = width_config_select == `DHT_CFG_CLOCK;
  assign en = {timer_control_reg[`DHT_CTL_BEN], timer_control_reg[`DHT_CTL_AEN]};
  assign stall = {timer_control_reg[`DHT_CTL_BSTALL], timer_control_reg[`DHT_CTL_ASTALL]};
  assign ote = {timer_control_reg[`DHT_CTL_BOTE], timer_control_reg[`DHT_CTL_AOTE]};
  assign cnt32 = {cnt_r[1], cnt_r[0]};
  assign ld32 = {ld_r[1], ld_r[0]};
  assign clk_sel_wr = wr && wb_req.adr == `DHT_OFS_CFG &&
                      wdat[2:0] == `DHT_CFG_CLOCK && !is_clk;
  assign ld_wr[0] = wr && wb_req.adr == `DHT_OFS_AILR;
  assign ld_wr[1] = wr && wb_req.adr == `DHT_OFS_BILR;

  // pin clock: s0 feeds only s1, the edge is taken between s1 and s2
  assign pin_rise = pin_s_r[1] & ~pin_s_r[2];
  assign tick = pin_rise && div_r == DIV_LAST;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      // clock enable overrides the stall bits so wall time never slips
      assign run[g] = en[g] &&
        !(stall[g] && dbg_halt && !timer_control_reg[`DHT_CTL_CLKEN]);
      assign step[g] = run[g] && psc_r[g] == pr_r[g];
      assign to16[g] = !mode32 && step[g] && cnt_r[g] == 16'h0000 && !ld_wr[g];
    end
  endgenerate
  // in joint mode the second mode field is never looked at
  assign oneshot[0] = mode_r[0] == `DHT_MODE_ONESHOT;
  assign oneshot[1] = !mode32 && mode_r[1] == `DHT_MODE_ONESHOT;
  assign to32 = mode32 && !is_clk && run[0] && cnt32 == 32'h0 && !ld_wr[0];
  assign match_ev = is_clk && run[0] && tick && cnt32 == first_half_match_value &&
                    !ld_wr[0] && !clk_sel_wr;

  always_comb begin
    ev = 16'h0000;
    ev[`DHT_EV_ATO] = to32 | to16[0];
    ev[`DHT_EV_BTO] = to16[1];
    ev[`DHT_EV_MATCH] = match_ev;
    clr = 16'h0000;
    if (wr && wb_req.adr == `DHT_OFS_ICR) begin
      clr = wdat[15:0] & `DHT_EV_MASK;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (wb_req.adr)
      `DHT_OFS_CFG: rd_mux = {29'h0, width_config_select};
      `DHT_OFS_AMODE: rd_mux = {30'h0, mode_r[0]};
      `DHT_OFS_BMODE: rd_mux = {30'h0, mode_r[1]};
      `DHT_OFS_CTL: rd_mux = {16'h0, timer_control_reg};
      `DHT_OFS_IMR: rd_mux = {16'h0, event_mask_reg};
      `DHT_OFS_RIS: rd_mux = {16'h0, raw_event_status_reg};
      `DHT_OFS_MIS: rd_mux = {16'h0, raw_event_status_reg & event_mask_reg};
      `DHT_OFS_AILR: rd_mux = mode32 ? ld32 : {16'h0, ld_r[0]};
      `DHT_OFS_BILR: rd_mux = {16'h0, ld_r[1]};
      `DHT_OFS_AMATCH: rd_mux = first_half_match_value;
      `DHT_OFS_APR: rd_mux = {24'h0, pr_r[0]};
      `DHT_OFS_BPR: rd_mux = {24'h0, pr_r[1]};
      `DHT_OFS_AR: rd_mux = mode32 ? cnt32 : {16'h0, cnt_r[0]};
      `DHT_OFS_BR: rd_mux = {16'h0, cnt_r[1]};
      default: rd_mux = 32'h0;
    endcase
  end

  // bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        rdat_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      width_config_select <= `DHT_CFG_JOINT;
      mode_r[0] <= 2'h0;
      mode_r[1] <= 2'h0;
      event_mask_reg <= 16'h0000;
      first_half_match_value <= 32'h0;
    end else if (wr) begin
      case (wb_req.adr)
        `DHT_OFS_CFG: width_config_select <= wdat[2:0];
        `DHT_OFS_AMODE: mode_r[0] <= wdat[1:0];
        `DHT_OFS_BMODE: mode_r[1] <= wdat[1:0];
        `DHT_OFS_IMR: event_mask_reg <= wdat[15:0] & `DHT_EV_MASK;
        `DHT_OFS_AMATCH: first_half_match_value <= wdat;
        default: ;
      endcase
    end
  end

  // a software write in the same cycle as a one-shot end keeps what was written
  always_ff @(posedge mclk) begin
    if (srst) begin
      timer_control_reg <= 16'h0000;
    end else if (wr && wb_req.adr == `DHT_OFS_CTL) begin
      timer_control_reg <= wdat[15:0] & `DHT_CTL_MASK;
    end else begin
      if ((to32 || to16[0]) && oneshot[0]) begin
        timer_control_reg[`DHT_CTL_AEN] <= 1'b0;
      end
      if (to16[1] && oneshot[1]) begin
        timer_control_reg[`DHT_CTL_BEN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ld_r[0] <= `DHT_RST_LOAD;
      ld_r[1] <= `DHT_RST_LOAD;
      pr_r[0] <= `DHT_RST_PRESC;
      pr_r[1] <= `DHT_RST_PRESC;
    end else if (wr) begin
      case (wb_req.adr)
        `DHT_OFS_AILR: begin
          ld_r[0] <= wdat[15:0];
          if (mode32) begin
            ld_r[1] <= wdat[31:16];
          end
        end
        `DHT_OFS_BILR: ld_r[1] <= wdat[15:0];
        `DHT_OFS_APR: pr_r[0] <= wdat[7:0];
        `DHT_OFS_BPR: pr_r[1] <= wdat[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_s_r <= 3'h0;
    end else begin
      pin_s_r <= {pin_s_r[1:0], capture_compare_pin};
    end
  end

  // divider idles at zero outside clock mode so each second starts clean
  always_ff @(posedge mclk) begin
    if (srst || !is_clk || !run[0]) begin
      div_r <= 16'h0;
    end else if (pin_rise) begin
      div_r <= tick ? 16'h0 : div_r + 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 2; i++) begin
        cnt_r[i] <= `DHT_RST_CNT;
        psc_r[i] <= `DHT_RST_PRESC;
      end
    end else if (clk_sel_wr) begin
      {cnt_r[1], cnt_r[0]} <= `DHT_CLOCK_FIRST;
    end else if (mode32) begin
      if (ld_wr[0]) begin
        {cnt_r[1], cnt_r[0]} <= wdat;
      end else if (is_clk) begin
        if (run[0] && tick) begin
          {cnt_r[1], cnt_r[0]} <= match_ev ? 32'h0 : cnt32 + 32'h1;
        end
      end else if (run[0]) begin
        {cnt_r[1], cnt_r[0]} <= (cnt32 == 32'h0) ? ld32 : cnt32 - 32'h1;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ld_wr[i]) begin
          cnt_r[i] <= wdat[15:0];
          psc_r[i] <= 8'h00;
        end else if (step[i]) begin
          psc_r[i] <= 8'h00;
          cnt_r[i] <= (cnt_r[i] == 16'h0000) ? ld_r[i] : cnt_r[i] - 16'h1;
        end else if (run[i]) begin
          psc_r[i] <= psc_r[i] + 8'h1;
        end
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      raw_event_status_reg <= 16'h0000;
    end else begin
      raw_event_status_reg <= (raw_event_status_reg & ~clr) | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      irq_r <= |(raw_event_status_reg & event_mask_reg);
      trig_r <= ((to32 | to16[0]) & ote[0]) | (to16[1] & ote[1]) |
                other_trig;
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;
  assign irq = irq_r;
  assign conv_trig = trig_r;

  a_reset_loads: assert property (@(posedge mclk)
    $past(srst) && !srst |-> cnt_r[0] == 16'hffff && cnt_r[1] == 16'hffff &&
      ld_r[0] == 16'hffff && ld_r[1] == 16'hffff && pr_r[0] == 8'h00 && pr_r[1] == 8'h00)
    else $error("reset values of counters, loads or prescales wrong");

  a_reset_idle: assert property (@(posedge mclk)
    $past(srst) && !srst |-> timer_control_reg == 16'h0 && irq == 1'b0 && !wb_rsp.ack)
    else $error("block not idle after reset");

  a_load_split: assert property (@(posedge mclk) disable iff (srst)
    ld_wr[0] && mode32 |=> ld_r[1] == $past(wdat[31:16]) && ld_r[0] == $past(wdat[15:0]))
    else $error("joint load write did not fill both halves");

  a_down_reload: assert property (@(posedge mclk) disable iff (srst)
    to32 && !clk_sel_wr |=> cnt32 == $past(ld32))
    else $error("joint counter did not reload after zero");

  a_oneshot_stop: assert property (@(posedge mclk) disable iff (srst)
    to32 && oneshot[0] && !(wr && wb_req.adr == `DHT_OFS_CTL) |=> !en[0] ##1 $stable(cnt32))
    else $error("one-shot did not stop at time-out");

  a_flag_hold: assert property (@(posedge mclk) disable iff (srst)
    ev[`DHT_EV_ATO] ##1 !clr[`DHT_EV_ATO] [*2] |=> raw_event_status_reg[`DHT_EV_ATO])
    else $error("time-out flag lost without a clear");

  a_irq_follow: assert property (@(posedge mclk) disable iff (srst)
    (raw_event_status_reg & event_mask_reg) != 16'h0 |=> irq)
    else $error("unmasked flag without interrupt");

  a_trig_gate: assert property (@(posedge mclk) disable iff (srst)
    !(ev[`DHT_EV_ATO] && ote[0]) && !(to16[1] && ote[1]) && !other_trig |=> !conv_trig)
    else $error("converter trigger without enabled time-out");

  a_presc_step: assert property (@(posedge mclk) disable iff (srst)
    !mode32 && run[0] && !ld_wr[0] && psc_r[0] != pr_r[0] |=> $stable(cnt_r[0]))
    else $error("16-bit count stepped before prescale expired");

  a_stall_hold: assert property (@(posedge mclk) disable iff (srst)
    mode32 && !is_clk && en[0] && stall[0] && dbg_halt &&
      !timer_control_reg[`DHT_CTL_CLKEN] && !wr |=> $stable(cnt32))
    else $error("counter moved while halted with stall set");

  a_clock_roll: assert property (@(posedge mclk) disable iff (srst)
    match_ev |=> cnt32 == 32'h0 && raw_event_status_reg[`DHT_EV_MATCH])
    else $error("clock match did not roll over to zero");

  a_clock_first: assert property (@(posedge mclk) disable iff (srst)
    clk_sel_wr |=> cnt32 == 32'h1 && is_clk)
    else $error("clock mode did not start at one");

  a_irq_drop: assert property (@(posedge mclk) disable iff (srst)
    (raw_event_status_reg & event_mask_reg) == 16'h0 |=> !irq)
    else $error("interrupt raised without an unmasked flag");

  a_trig_fire: assert property (@(posedge mclk) disable iff (srst)
    ev[`DHT_EV_ATO] && ote[0] |=> conv_trig)
    else $error("enabled time-out gave no converter trigger");

  a_periodic_keeps: assert property (@(posedge mclk) disable iff (srst)
    to32 && !oneshot[0] && !(wr && wb_req.adr == `DHT_OFS_CTL) |=> en[0])
    else $error("periodic timer stopped at time-out");

  a_half_oneshot: assert property (@(posedge mclk) disable iff (srst)
    to16[1] && oneshot[1] && !(wr && wb_req.adr == `DHT_OFS_CTL) |=> !en[1])
    else $error("16-bit one-shot kept its enable");

  a_load_take: assert property (@(posedge mclk) disable iff (srst)
    ld_wr[0] && mode32 |=> cnt32 == $past(wdat))
    else $error("joint counter did not take the new load");

  a_half_reload: assert property (@(posedge mclk) disable iff (srst)
    to16[0] && !clk_sel_wr |=> cnt_r[0] == $past(ld_r[0]))
    else $error("16-bit counter did not reload at time-out");

  a_count_down: assert property (@(posedge mclk) disable iff (srst)
    mode32 && !is_clk && run[0] && cnt32 != 32'h0 && !wr |=> cnt32 == $past(cnt32) - 32'h1)
    else $error("joint counter did not step down");

  a_joint_only: assert property (@(posedge mclk) disable iff (srst)
    mode32 && !is_clk && !run[0] && !wr |=> $stable(cnt32))
    else $error("half moved on its own in a 32-bit mode");

  a_presc_clear: assert property (@(posedge mclk) disable iff (srst)
    !mode32 && step[0] && !clk_sel_wr |=> psc_r[0] == 8'h00)
    else $error("prescaler not restarted after a step");

  a_match_clear: assert property (@(posedge mclk) disable iff (srst)
    clr[`DHT_EV_MATCH] && !ev[`DHT_EV_MATCH] |=> !raw_event_status_reg[`DHT_EV_MATCH])
    else $error("clock match flag survived its clear");

  a_clock_nostall: assert property (@(posedge mclk) disable iff (srst)
    is_clk && en[0] && timer_control_reg[`DHT_CTL_CLKEN] && tick && !match_ev && !wr |=>
      cnt32 == $past(cnt32) + 32'h1)
    else $error("clock mode count lost a tick");

  a_clock_tick: assert property (@(posedge mclk) disable iff (srst)
    is_clk && !tick && !wr |=> $stable(cnt32))
    else $error("clock mode counted without a divided tick");
endmodule

// >>> rtl/dht_timer_regs.svh
// Purpose: register offsets, field positions, reset values and counts of the timer block
// Assumes: byte addresses on a 32-bit classic wishbone, one aligned word per register
// Notes: included by the timer module and by the bench
// Behaviour
// - writing 0 to config selects joint 32-bit down mode, 1 selects clock mode
// - writing 0x4 to config splits into two independent 16-bit timers
// - in either 32-bit mode the halves act only as one 32-bit timer
// - reset sets both counters and loads to 0xffff, prescales to 0x00
// - after reset every control setting is cleared and the block stays idle
// - in 32-bit modes a first-half load write also fills the second half load
// - in 32-bit modes the first-half count read returns both halves, second high
// - in joint 32-bit down mode only the first-half mode field matters
// - enabled joint 32-bit counter counts down, reloads joint load one cycle after zero
// - one-shot stops at time-out and clears its enable; periodic keeps going
// - each time-out sets a raw flag held until software clears it
// - unmasked time-out also sets the masked flag and raises the interrupt
// - converter trigger pulses on time-out only with trigger enable set
// - converter triggers of all timer modules are ORed into one trigger
// - a load write while running is taken by the counter next cycle
// - with debug stall set, counting freezes while the processor is halted
// - clock mode counts up, starting at 1 on first selection
// - clock mode takes a 32.768 kHz pin clock and divides it to 1 Hz
// - in clock mode a count equal to match rolls over to 0 and continues
// - clock match sets raw and masked flags and interrupt; clear bit clears both
// - with clock enable set both debug stall bits are ignored
// - 16-bit halves are down-counters with 8-bit prescaler, mode field picks kind
// - prescale value p makes each count step last p+1 clocks
`ifndef DHT_TIMER_REGS_SVH
`define DHT_TIMER_REGS_SVH
`define DHT_OFS_CFG 8'h00
`define DHT_OFS_AMODE 8'h04
`define DHT_OFS_BMODE 8'h08
`define DHT_OFS_CTL 8'h0c
`define DHT_OFS_IMR 8'h18
`define DHT_OFS_RIS 8'h1c
`define DHT_OFS_MIS 8'h20
`define DHT_OFS_ICR 8'h24
`define DHT_OFS_AILR 8'h28
`define DHT_OFS_BILR 8'h2c
`define DHT_OFS_AMATCH 8'h30
`define DHT_OFS_APR 8'h38
`define DHT_OFS_BPR 8'h3c
`define DHT_OFS_AR 8'h48
`define DHT_OFS_BR 8'h4c
`define DHT_CFG_JOINT 3'h0
`define DHT_CFG_CLOCK 3'h1
`define DHT_CFG_SPLIT 3'h4
`define DHT_MODE_ONESHOT 2'h1
`define DHT_MODE_PERIODIC 2'h2
`define DHT_CTL_AEN 0
`define DHT_CTL_ASTALL 1
`define DHT_CTL_CLKEN 4
`define DHT_CTL_AOTE 5
`define DHT_CTL_BEN 8
`define DHT_CTL_BSTALL 9
`define DHT_CTL_BOTE 13
`define DHT_CTL_MASK 16'h2333
`define DHT_EV_ATO 0
`define DHT_EV_MATCH 3
`define DHT_EV_BTO 8
`define DHT_EV_MASK 16'h0109
`define DHT_RST_CNT 16'hffff
`define DHT_RST_LOAD 16'hffff
`define DHT_RST_PRESC 8'h00
`define DHT_CLOCK_FIRST 32'h0000_0001
`define DHT_CLOCK_IN_HZ 32768
`define DHT_CLOCK_OUT_HZ 1
`endif
